// ### design/sram_tap_consts.vh
// constants for the sram test access port instruction logic
// =====================================================================
// Notes on behaviour
// - capture-ir loads 01 into the two lowest instruction bits
// - shift-ir places instruction register between tdi and tdo
// - new instruction takes effect only at update-ir
// - code 111 selects the one-bit bypass register in shift-dr
// - code 100 captures pin levels and shifts boundary register
// - pinless boundary cells capture their fixed default value
// - code 000 selects extest with boundary register in path
// - extest does not isolate functional inputs from the core
// - extest drives boundary contents on outputs at falling tck
// - extest capture-dr loads pins and defaults on rising tck
// - code 001 captures id rom and shifts id register
// - id instruction loaded at power-up and test-logic-reset
// - code 010 floats ram outputs and shifts boundary register
// - reserved codes 011 and 110 behave like bypass
// - codes are binary, msb leftmost, lsb rightmost
// - id register is 32 bits, bit 0 shifted out first
// - five tck rising edges with tms high reach test-logic-reset
// - tms and tdi sampled on rising tck, tdo changes on falling
// - bypass register is exactly one bit long
`ifndef SRAM_TAP_CONSTS_VH
`define SRAM_TAP_CONSTS_VH
// =====================================================================
// instruction codes
`define IR_LEN 3
`define INS_EXTEST 3'h0
`define INS_IDCODE 3'h1
`define INS_SAMPLE_Z 3'h2
`define INS_RESERVED_A 3'h3
`define INS_SAMPLE 3'h4
`define INS_PRIVATE 3'h5
`define INS_RESERVED_B 3'h6
`define INS_BYPASS 3'h7
`define IR_CAPTURE 2'h1
// =====================================================================
// tap states
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SH_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PA_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'ha
`define ST_SH_IR 4'hb
`define ST_EX1_IR 4'hc
`define ST_PA_IR 4'hd
`define ST_EX2_IR 4'he
`define ST_UPD_IR 4'hf
// =====================================================================
// id register
`define ID_LEN 32
`define ID_UPPER 20'h0_0000
`endif

// ### design/tap_fsm.v
// tap controller state machine
`timescale 1ns/100ps
`include "sram_tap_consts.vh"
module tap_fsm
(
  // clock and reset
  input wire clk,
  input wire rst,
  // advance on tck rise
  input wire step,
  input wire tms,
  // state
  output reg [3:0] state_r
);
  reg [3:0] state_nxt;

  always @*
  begin
    case (state_r)
      `ST_RESET: state_nxt = tms ? `ST_RESET : `ST_IDLE;
      `ST_IDLE: state_nxt = tms ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_DR: state_nxt = tms ? `ST_SEL_IR : `ST_CAP_DR;
      `ST_CAP_DR: state_nxt = tms ? `ST_EX1_DR : `ST_SH_DR;
      `ST_SH_DR: state_nxt = tms ? `ST_EX1_DR : `ST_SH_DR;
      `ST_EX1_DR: state_nxt = tms ? `ST_UPD_DR : `ST_PA_DR;
      `ST_PA_DR: state_nxt = tms ? `ST_EX2_DR : `ST_PA_DR;
      `ST_EX2_DR: state_nxt = tms ? `ST_UPD_DR : `ST_SH_DR;
      `ST_UPD_DR: state_nxt = tms ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_IR: state_nxt = tms ? `ST_RESET : `ST_CAP_IR;
      `ST_CAP_IR: state_nxt = tms ? `ST_EX1_IR : `ST_SH_IR;
      `ST_SH_IR: state_nxt = tms ? `ST_EX1_IR : `ST_SH_IR;
      `ST_EX1_IR: state_nxt = tms ? `ST_UPD_IR : `ST_PA_IR;
      `ST_PA_IR: state_nxt = tms ? `ST_EX2_IR : `ST_PA_IR;
      `ST_EX2_IR: state_nxt = tms ? `ST_UPD_IR : `ST_SH_IR;
      `ST_UPD_IR: state_nxt = tms ? `ST_SEL_DR : `ST_IDLE;
      default: state_nxt = `ST_RESET;
    endcase
  end

  // =====================================================================
  // state register
  always @(posedge clk)
  begin
    if (rst)
      state_r <= `ST_RESET;
    else if (step)
      state_r <= state_nxt;
  end
endmodule // tap_fsm

// ### design/sram_tap.v
// test access port instruction logic of a burst sram
`timescale 1ns/100ps
`include "sram_tap_consts.vh"
module sram_tap
#(
  parameter BSR_LEN = 8,
  // arbitrary maker code, not a real assignment
  parameter [10:0] MAKER_CODE = 11'h2_A5,
  // fixed values of pinless boundary cells
  parameter [BSR_LEN-1:0] PINLESS_MASK = 8'h80,
  parameter [BSR_LEN-1:0] PINLESS_VAL = 8'h80
)
(
  // clock and reset
  input wire SYS_CLK,
  input wire RST,
  // test port pins
  input wire TCK,
  input wire TMS,
  input wire TDI,
  output reg TDO,
  output reg TDO_OE_N,
  // ram pin ring
  input wire [BSR_LEN-1:0] PIN_LEVELS,
  input wire [BSR_LEN-1:0] FUNC_OUT,
  input wire FUNC_OE_N,
  output reg [BSR_LEN-1:0] RAM_OUT,
  output reg RAM_OE_N,
  // status
  output reg [2:0] ACTIVE_INS
);
  // =====================================================================
  // pin synchronisers
  reg [1:0] tck_s_r;
  reg [1:0] tms_s_r;
  reg [1:0] tdi_s_r;
  reg tck_d_r;
  reg [BSR_LEN-1:0] pin_s1_r;
  reg [BSR_LEN-1:0] pin_s2_r;
  wire tck_rise;
  wire tck_fall;
  wire [3:0] state;

  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      tck_s_r <= 2'h0;
      tms_s_r <= 2'h3;
      tdi_s_r <= 2'h3;
      tck_d_r <= 1'b0;
      pin_s1_r <= {BSR_LEN{1'b0}};
      pin_s2_r <= {BSR_LEN{1'b0}};
    end
    else
    begin
      tck_s_r <= {tck_s_r[0], TCK};
      tms_s_r <= {tms_s_r[0], TMS};
      tdi_s_r <= {tdi_s_r[0], TDI};
      tck_d_r <= tck_s_r[1];
      pin_s1_r <= PIN_LEVELS;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign tck_rise = tck_s_r[1] & ~tck_d_r;
  assign tck_fall = ~tck_s_r[1] & tck_d_r;

  tap_fsm tap_fsm_inst
  (
    .clk(SYS_CLK),
    .rst(RST),
    .step(tck_rise),
    .tms(tms_s_r[1]),
    .state_r(state)
  );

  // =====================================================================
  // instruction decode
  localparam SEL_BYP = 2'h0;
  localparam SEL_ID = 2'h1;
  localparam SEL_BSR = 2'h2;

  function [1:0] dr_select;
    input [2:0] ins;
    begin
      case (ins)
        `INS_EXTEST: dr_select = SEL_BSR;
        `INS_IDCODE: dr_select = SEL_ID;
        `INS_SAMPLE_Z: dr_select = SEL_BSR;
        `INS_SAMPLE: dr_select = SEL_BSR;
        default: dr_select = SEL_BYP;
      endcase
    end
  endfunction

  // =====================================================================
  // shift registers advanced on tck rise; ir_r and upd_r loaded on tck fall, ir_r also in reset state
  reg [2:0] ir_sh_r;
  reg [2:0] ir_r;
  reg byp_r;
  reg [`ID_LEN-1:0] id_r;
  reg [BSR_LEN-1:0] bsr_r;
  reg [BSR_LEN-1:0] upd_r;
  wire [1:0] sel;
  wire [BSR_LEN-1:0] cap_val;
  wire [`ID_LEN-1:0] id_rom;
  wire tdi_v;

  assign sel = dr_select(ir_r);
  assign tdi_v = tdi_s_r[1];
  assign id_rom = {`ID_UPPER, MAKER_CODE, 1'b1};
  assign cap_val = (pin_s2_r & ~PINLESS_MASK) | (PINLESS_VAL & PINLESS_MASK);

  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ir_sh_r <= `INS_IDCODE;
      ir_r <= `INS_IDCODE;
      byp_r <= 1'b0;
      id_r <= {`ID_LEN{1'b0}};
      bsr_r <= {BSR_LEN{1'b0}};
    end
    else
    begin
      // id held in reset state, even with tck stopped there
      if (state == `ST_RESET)
        ir_r <= `INS_IDCODE;
      // update ir on the fall inside update-ir
      else if (tck_fall && (state == `ST_UPD_IR))
        ir_r <= ir_sh_r;
      if (tck_rise)
      begin
        case (state)
          `ST_CAP_IR: ir_sh_r <= {ir_r[2], `IR_CAPTURE};
          `ST_SH_IR: ir_sh_r <= {tdi_v, ir_sh_r[2:1]};
          `ST_CAP_DR:
          begin
            byp_r <= 1'b0;
            if (sel == SEL_ID)
              id_r <= id_rom;
            if (sel == SEL_BSR)
              bsr_r <= cap_val;
          end
          `ST_SH_DR:
          begin
            if (sel == SEL_BYP)
              byp_r <= tdi_v;
            if (sel == SEL_ID)
              id_r <= {tdi_v, id_r[`ID_LEN-1:1]};
            if (sel == SEL_BSR)
              bsr_r <= {tdi_v, bsr_r[BSR_LEN-1:1]};
          end
          default: ;
        endcase
      end
    end
  end

  // =====================================================================
  // outputs; tdo, its enable and the update stage changed on tck fall, ram outputs and status every clock
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      TDO <= 1'b0;
      TDO_OE_N <= 1'b1;
      upd_r <= {BSR_LEN{1'b0}};
      RAM_OUT <= {BSR_LEN{1'b0}};
      RAM_OE_N <= 1'b1;
      ACTIVE_INS <= `INS_IDCODE;
    end
    else
    begin
      ACTIVE_INS <= ir_r;
      // core keeps following its pins; float under sample-z
      if (ir_r == `INS_EXTEST)
      begin
        RAM_OUT <= upd_r;
        RAM_OE_N <= 1'b0;
      end
      else
      begin
        RAM_OUT <= FUNC_OUT;
        RAM_OE_N <= (ir_r == `INS_SAMPLE_Z) ? 1'b1 : FUNC_OE_N;
      end
      if (tck_fall)
      begin
        // drive on the fall inside update states
        if ((state == `ST_UPD_IR) || (state == `ST_UPD_DR))
          upd_r <= bsr_r;
        if (state == `ST_SH_IR)
        begin
          TDO <= ir_sh_r[0];
          TDO_OE_N <= 1'b0;
        end
        else if (state == `ST_SH_DR)
        begin
          TDO_OE_N <= 1'b0;
          case (sel)
            SEL_ID: TDO <= id_r[0];
            SEL_BSR: TDO <= bsr_r[0];
            default: TDO <= byp_r;
          endcase
        end
        else
          TDO_OE_N <= 1'b1;
      end
    end
  end
endmodule // sram_tap

// ### sim/sram_tap_monitor.sv
// assertion checker on the sram test port top ports
`timescale 1ns/100ps
module sram_tap_monitor
#(parameter BSR_LEN = 8)
(
  // watched ports
  input wire SYS_CLK,
  input wire RST,
  input wire TCK,
  input wire TDO,
  input wire TDO_OE_N,
  input wire [BSR_LEN-1:0] FUNC_OUT,
  input wire FUNC_OE_N,
  input wire [BSR_LEN-1:0] RAM_OUT,
  input wire RAM_OE_N,
  input wire [2:0] ACTIVE_INS
);
  // =====
  // properties
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  rst_ins_a: assert property ($fell(RST) |-> ACTIVE_INS == 3'h1)
    else $error("no id after reset");
  rst_tdo_a: assert property ($fell(RST) |-> !TDO && TDO_OE_N)
    else $error("tdo after reset");
  float_oe_a: assert property ((ACTIVE_INS == 3'h2) [*2] |-> RAM_OE_N)
    else $error("outputs not floated");
  extest_oe_a: assert property ((ACTIVE_INS == 3'h0) [*2] |-> !RAM_OE_N)
    else $error("extest not driving");
  pass_out_a: assert property (!$past(RST) && |$past(ACTIVE_INS)
    && |ACTIVE_INS |-> RAM_OUT == $past(FUNC_OUT)) else $error("ram out");
  pass_oe_a: assert property (!$past(RST) && $past(ACTIVE_INS[0])
    && ACTIVE_INS[0] |-> RAM_OE_N == $past(FUNC_OE_N)) else $error("ram oe");
  tdo_fall_a: assert property ($changed(TDO) |-> !$past(TCK, 2))
    else $error("tdo moved with tck high");
  ins_fall_a: assert property (ACTIVE_INS != 3'h1
    && $changed(ACTIVE_INS) |-> !$past(TCK, 2))
    else $error("instruction moved with tck high");
  cover property (ACTIVE_INS == 3'h0 && !RAM_OE_N);
  cover property (ACTIVE_INS == 3'h2 && RAM_OE_N);
  cover property ($fell(TDO_OE_N));
endmodule // sram_tap_monitor
bind sram_tap sram_tap_monitor #(.BSR_LEN(BSR_LEN)) mon_inst (
  .SYS_CLK(SYS_CLK), .RST(RST), .TCK(TCK), .TDO(TDO), .TDO_OE_N(TDO_OE_N),
  .FUNC_OUT(FUNC_OUT), .FUNC_OE_N(FUNC_OE_N), .RAM_OUT(RAM_OUT),
  .RAM_OE_N(RAM_OE_N), .ACTIVE_INS(ACTIVE_INS));

// ### sim/tap_host.sv
// boundary scan controller model on the far side of the test port
`timescale 1ns/100ps
module tap_host
(
  // test port pins
  output reg tck = 1'b0,
  output reg tms = 1'b1,
  output reg tdi = 1'b1,
  input wire tdo
);
  // =====
  // one 125 ns tck period; tck rests low between frames
  task tick(input m, input d, output o);
  begin
    tms = m;
    tdi = d;
    #62.5;
    // tdo taken just before the rise
    o = tdo;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  end
  endtask
  task reset5;
    reg o;
  begin
    repeat (5) tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
  end
  endtask
  // scan from idle, lsb first, back to idle
  task scan(input ir, input [31:0] din, input integer n,
    output [31:0] dout);
    integer i;
    reg o;
  begin
    dout = 32'h0;
    tick(1'b1, 1'b1, o);
    if (ir)
      tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
    for (i = 0; i < n; i = i + 1)
    begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    // released lines rest at their pull-up level
    tms = 1'b1;
    tdi = 1'b1;
  end
  endtask
endmodule // tap_host

// ### sim/testbench.sv
// self-checking bench for the sram test port instruction logic
`timescale 1ns/100ps
module testbench;
  // =====
  // pins, model state and counters
  // arbitrary maker code
  localparam [10:0] maker_id = 11'h2_A5;
  reg SYS_CLK = 1'b0;
  reg RST = 1'b1;
  reg [7:0] PIN_LEVELS = 8'h0;
  reg [7:0] FUNC_OUT = 8'h0;
  reg FUNC_OE_N = 1'b1;
  wire TCK, TMS, TDI, TDO, TDO_OE_N, RAM_OE_N, tdo_pin;
  wire [7:0] RAM_OUT;
  wire [2:0] ACTIVE_INS;
  integer error_cnt = 0, samples_checked = 0, code;
  reg [2:0] prev = 3'h1;
  reg o;
  reg [31:0] rnd = 32'h6dd8_2775, dout, exp;
  always #5 SYS_CLK = ~SYS_CLK;
  // a released tdo floats, so a late enable shows as a bad bit
  assign tdo_pin = TDO_OE_N ? 1'bz : TDO;
  sram_tap #(.MAKER_CODE(maker_id)) sram_tap_inst (.SYS_CLK(SYS_CLK),
    .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO),
    .TDO_OE_N(TDO_OE_N), .PIN_LEVELS(PIN_LEVELS), .FUNC_OUT(FUNC_OUT),
    .FUNC_OE_N(FUNC_OE_N), .RAM_OUT(RAM_OUT), .RAM_OE_N(RAM_OE_N),
    .ACTIVE_INS(ACTIVE_INS));
  tap_host tap_host_inst (.tck(TCK), .tms(TMS), .tdi(TDI), .tdo(tdo_pin));
  function [31:0] next_rand(input [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [31:0] got, input [31:0] want);
  begin
    samples_checked = samples_checked + 1;
    if (got !== want)
    begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, want);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // the whole run needs about 30 us of tck traffic
  initial
  begin
    #300000;
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  initial
  begin
    repeat (10) @(negedge SYS_CLK);
    RST = 1'b0;
    repeat (3) @(negedge SYS_CLK);
    tap_host_inst.reset5;
    tap_host_inst.scan(1'b0, rnd, 32, dout);
    chk(dout, {20'h0_0000, maker_id, 1'b1});
    for (code = 0; code < 8; code = code + 1)
    begin
      rnd = next_rand(rnd);
      @(negedge SYS_CLK);
      // ram pins held still through each capture
      {FUNC_OE_N, FUNC_OUT, PIN_LEVELS} = rnd[24:8];
      // reserved codes loaded only to probe bypass
      tap_host_inst.scan(1'b1, code, 3, dout);
      chk(dout, {29'h0, prev[2], 2'b01});
      @(negedge SYS_CLK);
      chk({29'h0, ACTIVE_INS}, code);
      case (code)
        0, 2, 4: exp = {24'h0, 1'b1, PIN_LEVELS[6:0]};
        1: exp = {24'h0, maker_id[6:0], 1'b1};
        default: exp = {24'h0, rnd[6:0], 1'b0};
      endcase
      tap_host_inst.scan(1'b0, rnd, 8, dout);
      @(negedge SYS_CLK);
      chk(dout, exp);
      o = code == 2 || code != 0 && FUNC_OE_N;
      chk({31'h0, RAM_OE_N}, {31'h0, o});
      chk({24'h0, RAM_OUT}, {24'h0, code == 0 ? rnd[7:0] : FUNC_OUT});
      prev = code[2:0];
    end
    RST = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    RST = 1'b0;
    repeat (3) @(negedge SYS_CLK);
    chk({29'h0, ACTIVE_INS}, 1);
    tap_host_inst.reset5;
    tap_host_inst.scan(1'b1, 4, 3, dout);
    tap_host_inst.tick(1'b1, 1'b1, o);
    tap_host_inst.tick(1'b0, 1'b1, o);
    tap_host_inst.tick(1'b0, 1'b1, o);
    tap_host_inst.reset5;
    @(negedge SYS_CLK);
    chk({29'h0, ACTIVE_INS}, 1);
    print_verdict;
  end
endmodule // testbench
